// >>> verilog/lcs_seq.sv
// LIN/UART command sequencer with AXI4-Lite register access
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module lcs_seq (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic      [1:0]  s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic      [31:0] s_rdata,
	output logic      [1:0]  s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	input  wire logic        lin_rx,
	output logic             lin_tx
);
	import lcs_pkg::*;

	lcs_state_t  st_q, st_d;
	logic [2:0]  cmd_q, cmd_d, sts_q;
	logic        on_q, leg_q, abt, hold_full_q, ovp_q;
	logic [5:0]  err_q, err_set, err_clr, id_q;
	logic [3:0]  rxl_q, txl_q, sel_q, seq_q, rcnt_q, tcnt_q;
	logic [15:0] baud_q, tbt_q, fdiv_q;
	logic [7:0]  buf_q [DBUF_DEPTH];
	logic [7:0]  cs_q, hold_q, tmo_q, rb, wd, lin_byte, idfull, tmo_lim;
	logic [13:0] tsh_q, tld_v;
	logic [1:0]  hph_q;
	logic [3:0]  tld_n, ntx, nrx, nrsp;
	logic        rdn, rfe, rbrk;

	function automatic logic [7:0] add8c(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	function automatic logic [1:0] idpar(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4]};
	endfunction

	function automatic logic [3:0] len13(input logic [1:0] c);
		return (c == 2'h3) ? 4'h8 : (c == 2'h2) ? 4'h4 : 4'h2;
	endfunction

	// Bus decode
	logic wr_go, rd_go, wa_ok, ra_ok, w_ctrl, w_sts, w_err, w_len, w_id;
	logic w_sel, w_baud, w_dat, r_dat;
	assign wr_go     = s_awvalid & s_wvalid & ~s_bvalid;
	assign rd_go     = s_arvalid & ~s_rvalid;
	assign s_awready = wr_go;
	assign s_wready  = wr_go;
	assign s_arready = rd_go;
	assign wd        = s_wdata[7:0];
	assign wa_ok     = (s_awaddr <= A_BAUD) & (s_awaddr[1:0] == 2'h0);
	assign ra_ok     = (s_araddr <= A_BAUD) & (s_araddr[1:0] == 2'h0);
	assign w_ctrl    = wr_go & s_wstrb[0] & (s_awaddr == A_CTRL);
	assign w_sts     = wr_go & s_wstrb[0] & (s_awaddr == A_STS);
	assign w_err     = wr_go & s_wstrb[0] & (s_awaddr == A_ERR);
	assign w_len     = wr_go & s_wstrb[0] & (s_awaddr == A_LEN);
	assign w_id      = wr_go & s_wstrb[0] & (s_awaddr == A_ID);
	assign w_sel     = wr_go & s_wstrb[0] & (s_awaddr == A_SEL);
	assign w_baud    = wr_go & (s_awaddr == A_BAUD);
	assign w_dat     = wr_go & s_wstrb[0] & (s_awaddr == A_DATA);
	assign r_dat     = rd_go & (s_araddr == A_DATA);

	// Mode and status decode
	logic uart_m, lin_m, rsp_st, run_st, tbusy, tx_last, uart_ld, lin_ld, tx_need;
	logic txh_done, rsp_done, err_stop, cs_bad, tmo_hit, rsp_framing_error_flag, hdr_id;
	logic enh, uart_rx, uart_txe;
	assign uart_m   = (st_q == ST_UART);
	assign lin_m    = (st_q != ST_OFF) & ~uart_m;
	assign rsp_st   = (st_q == ST_RXR) | (st_q == ST_TXR);
	assign run_st   = rsp_st | (st_q == ST_TXH);
	assign idfull   = {idpar(id_q), id_q};
	assign ntx      = (txl_q > DBUF_N) ? DBUF_N : txl_q;
	assign nrx      = (rxl_q > DBUF_N) ? DBUF_N : rxl_q;
	assign nrsp     = (st_q == ST_TXR) ? ntx : nrx;
	assign tbusy    = (tcnt_q != 4'h0);
	assign tx_last  = tbusy & (tbt_q == 16'h0000) & (tcnt_q == 4'h1);
	assign uart_rx  = uart_m & cmd_q[1] & rdn;
	assign uart_txe = uart_m & tx_last;

	// Checksum seed: enhanced includes identifier except for ids 60..63 or when C_LEG is set
	assign enh = ~leg_q & (id_q < CLASSIC_ID);

	// Transmit loading: header fields, response bytes, or a UART character
	assign tx_need  = ~tbusy & (((st_q == ST_TXH) & (seq_q < 4'h3))
		| ((st_q == ST_TXR) & (seq_q <= ntx)));
	assign lin_ld   = tx_need;
	assign uart_ld  = w_dat & uart_m & cmd_q[0] & ~tbusy;
	assign lin_byte = (st_q == ST_TXH) ? ((seq_q == 4'h1) ? SYNC_CHR : idfull)
		: (seq_q < ntx) ? buf_q[seq_q[2:0]] : ~cs_q;
	assign tld_v    = uart_ld ? {4'h0, 1'b1, wd, 1'b0}
		: ((st_q == ST_TXH) & (seq_q == 4'h0)) ? BRK_FRAME
		: {4'h0, 1'b1, lin_byte, 1'b0};
	assign tld_n    = (~uart_ld & (st_q == ST_TXH) & (seq_q == 4'h0)) ? BRK_LEN : FRM_LEN;

	// Completion and error terms of the running function
	assign txh_done = (st_q == ST_TXH) & (seq_q == 4'h3) & ~tbusy;
	assign rsp_done = ((st_q == ST_TXR) & (seq_q == ntx + 4'h1) & ~tbusy)
		| ((st_q == ST_RXR) & rdn & ~rbrk & ~rfe & (rcnt_q == nrx) & ~cs_bad);
	assign rsp_framing_error_flag = (st_q == ST_RXR) & rdn & ~rbrk & rfe;
	assign cs_bad   = (st_q == ST_RXR) & rdn & ~rbrk & ~rfe & (rcnt_q == nrx)
		& (add8c(cs_q, rb) != 8'hff);
	assign tmo_lim  = {nrsp, 4'h0} + TMO_MARGIN;
	assign tmo_hit  = rsp_st & (tmo_q > tmo_lim);
	assign err_stop = rsp_framing_error_flag | cs_bad | tmo_hit;
	assign hdr_id   = lin_m & (hph_q == 2'h2) & rdn & ~rbrk;

	// Command decode and state selection
	always_comb
	begin
		st_d  = st_q;
		cmd_d = cmd_q;
		abt   = 1'b0;
		if (w_ctrl)
		begin
			cmd_d = wd[2:0];
			if (!wd[C_ON])
				st_d = ST_OFF;
			else if (wd[2])
				st_d = ST_UART;
			else
			begin
				case (wd[1:0])
					2'h0:
					begin
						st_d = ST_HDR;
						abt  = run_st;
					end
					2'h1: st_d = ST_TXH;
					2'h2: st_d = ST_RXR;
					2'h3: st_d = ST_TXR;
					default: st_d = ST_HDR;
				endcase
			end
		end
		else if (txh_done | rsp_done | err_stop)
		begin
			cmd_d = 3'h0;
			st_d  = ST_HDR;
		end
	end

	// Flag set terms; set wins over clear
	assign err_set = {tmo_hit, cs_bad,
		hdr_id & (rb[7:6] != idpar(rb[5:0])), abt,
		r_dat & uart_m & ovp_q, rdn & rfe & (st_q != ST_OFF)};
	assign err_clr = w_err ? wd[5:0] : 6'h00;

	// Bus answer registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_bvalid <= 1'b0;
			s_bresp  <= RESP_OK;
			s_rvalid <= 1'b0;
			s_rresp  <= RESP_OK;
			s_rdata  <= 32'h0000_0000;
		end
		else
		begin
			if (wr_go)
			begin
				s_bvalid <= 1'b1;
				s_bresp  <= wa_ok ? RESP_OK : RESP_SLV;
			end
			else if (s_bready)
				s_bvalid <= 1'b0;
			if (rd_go)
			begin
				s_rvalid <= 1'b1;
				s_rresp  <= ra_ok ? RESP_OK : RESP_SLV;
				s_rdata  <= 32'h0000_0000;
				case (s_araddr)
					A_CTRL: s_rdata[7:0] <= {3'h0, leg_q, on_q, cmd_q};
					A_STS:  s_rdata[7:0] <= {4'h0, err_q != 6'h00, sts_q};
					A_ERR:  s_rdata[7:0] <= {2'h0, err_q};
					A_LEN:  s_rdata[7:0] <= {txl_q, rxl_q};
					A_ID:   s_rdata[7:0] <= idfull;
					A_SEL:  s_rdata[7:0] <= {4'h0, sel_q};
					A_DATA: s_rdata[7:0] <= uart_m ? hold_q : buf_q[sel_q[2:0]];
					A_BAUD: s_rdata[15:0] <= baud_q;
					default: s_rdata <= 32'h0000_0000;
				endcase
			end
			else if (s_rready)
				s_rvalid <= 1'b0;
		end
	end

	// Control, length, identifier and flag registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q   <= ST_OFF;
			cmd_q  <= 3'h0;
			on_q   <= 1'b0;
			leg_q  <= 1'b0;
			sts_q  <= 3'h0;
			err_q  <= 6'h00;
			rxl_q  <= 4'h0;
			txl_q  <= 4'h0;
			id_q   <= 6'h00;
			sel_q  <= 4'h0;
			baud_q <= BAUD_RST;
		end
		else
		begin
			st_q  <= st_d;
			cmd_q <= cmd_d;
			err_q <= (err_q & ~err_clr) | err_set;
			sts_q[S_RXD]  <= (sts_q[S_RXD] & ~(w_sts & wd[S_RXD]) & ~(r_dat & uart_m))
				| uart_rx | (rsp_done & (st_q == ST_RXR));
			sts_q[S_TXD]  <= (sts_q[S_TXD] & ~(w_sts & wd[S_TXD]) & ~uart_ld)
				| uart_txe | (rsp_done & (st_q == ST_TXR));
			sts_q[S_IDOK] <= (sts_q[S_IDOK] & ~(w_sts & wd[S_IDOK])) | hdr_id | txh_done;
			if (w_ctrl)
			begin
				on_q  <= wd[C_ON];
				leg_q <= wd[C_LEG];
			end
			if (w_id)
				id_q <= wd[5:0];
			if (hdr_id)
				id_q <= rb[5:0];
			if (w_len)
			begin
				rxl_q <= wd[3:0];
				txl_q <= wd[7:4];
			end
			if (leg_q & (hdr_id | txh_done))
			begin
				rxl_q <= len13(hdr_id ? rb[5:4] : id_q[5:4]);
				txl_q <= len13(hdr_id ? rb[5:4] : id_q[5:4]);
			end
			if (w_sel)
				sel_q <= wd[3:0];
			else if ((w_dat | r_dat) & lin_m & sel_q[SEL_AI])
				sel_q[2:0] <= sel_q[2:0] + 3'h1;
			if (w_baud & s_wstrb[0])
				baud_q[7:0] <= wd;
			if (w_baud & s_wstrb[1])
				baud_q[15:8] <= s_wdata[15:8];
		end
	end

	// Transmit shifter; any stop returns the line to recessive
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tsh_q  <= 14'h0000;
			tcnt_q <= 4'h0;
			tbt_q  <= 16'h0000;
			lin_tx <= 1'b1;
		end
		else if ((st_d == ST_OFF) | abt | err_stop)
		begin
			tcnt_q <= 4'h0;
			lin_tx <= 1'b1;
		end
		else if (uart_ld | lin_ld)
		begin
			tsh_q  <= tld_v;
			tcnt_q <= tld_n;
			tbt_q  <= baud_q - 16'h0001;
			lin_tx <= tld_v[0];
		end
		else if (tbusy & (tbt_q == 16'h0000))
		begin
			tsh_q  <= {1'b1, tsh_q[13:1]};
			tcnt_q <= tcnt_q - 4'h1;
			tbt_q  <= baud_q - 16'h0001;
			lin_tx <= (tcnt_q == 4'h1) ? 1'b1 : tsh_q[1];
		end
		else if (tbusy)
			tbt_q <= tbt_q - 16'h0001;
	end

	// Header capture, response counters, checksum and frame timeout
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hph_q  <= 2'h0;
			seq_q  <= 4'h0;
			rcnt_q <= 4'h0;
			cs_q   <= 8'h00;
			fdiv_q <= 16'h0000;
			tmo_q  <= 8'h00;
		end
		else
		begin
			if (!lin_m | (rbrk & rdn))
				hph_q <= {1'b0, lin_m};
			else if (rdn)
				hph_q <= ((hph_q == 2'h1) & (rb == SYNC_CHR) & ~rfe) ? 2'h2 : 2'h0;
			if (w_ctrl)
			begin
				seq_q  <= 4'h0;
				rcnt_q <= 4'h0;
				fdiv_q <= 16'h0000;
				tmo_q  <= 8'h00;
				cs_q   <= enh ? idfull : 8'h00;
			end
			else
			begin
				if (lin_ld)
					seq_q <= seq_q + 4'h1;
				if (lin_ld & (st_q == ST_TXR) & (seq_q < ntx))
					cs_q <= add8c(cs_q, lin_byte);
				if ((st_q == ST_RXR) & rdn & ~rbrk & ~rfe & (rcnt_q < nrx))
				begin
					rcnt_q <= rcnt_q + 4'h1;
					cs_q   <= add8c(cs_q, rb);
				end
				fdiv_q <= (fdiv_q >= baud_q) ? 16'h0000 : fdiv_q + 16'h0001;
				if (rsp_st & (fdiv_q >= baud_q))
					tmo_q <= tmo_q + 8'h01;
			end
		end
	end

	// Response buffer and UART holding stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < DBUF_DEPTH; i++)
				buf_q[i] <= 8'h00;
			hold_q      <= 8'h00;
			hold_full_q <= 1'b0;
			ovp_q       <= 1'b0;
		end
		else
		begin
			if ((st_q == ST_RXR) & rdn & ~rbrk & ~rfe & (rcnt_q < nrx))
				buf_q[rcnt_q[2:0]] <= rb;
			else if (w_dat & lin_m)
				buf_q[sel_q[2:0]] <= wd;
			if (r_dat & uart_m)
			begin
				hold_full_q <= 1'b0;
				ovp_q       <= 1'b0;
			end
			if (uart_rx)
			begin
				hold_q      <= rb;
				hold_full_q <= 1'b1;
				ovp_q       <= hold_full_q & ~r_dat;
			end
		end
	end

	lcs_rxb lcs_rxb_i (
		.clk     (clk),
		.rst_n   (rst_n),
		.rx_pin  (lin_rx),
		.en      (st_q != ST_OFF),
		.bit_cyc (baud_q),
		.byte_q  (rb),
		.done_q  (rdn),
		.fe_q    (rfe),
		.brk_q   (rbrk)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_off_now: assert property (w_ctrl & ~wd[C_ON] |=> st_q == ST_OFF ##1 lin_tx)
		else $error("disable not immediate");
	chk_lin_decode: assert property (w_ctrl & wd[C_ON] & ~wd[2] & (wd[1:0] == 2'h2)
		|=> st_q == ST_RXR)
		else $error("receive response not selected");
	chk_uart_sel: assert property (w_ctrl & wd[C_ON] & wd[2] |=> uart_m)
		else $error("uart not selected");
	chk_txh_end: assert property (txh_done & ~w_ctrl |=> cmd_q == 3'h0 && sts_q[S_IDOK])
		else $error("header send did not return");
	chk_rsp_end: assert property (rsp_done & ~w_ctrl |=> cmd_q == 3'h0 && st_q == ST_HDR)
		else $error("response did not return");
	chk_abort_flag: assert property (run_st & w_ctrl & wd[C_ON] & (wd[2:0] == 3'h0)
		|=> err_q[E_ABT] && st_q == ST_HDR ##1 lin_tx)
		else $error("abort not flagged");
	chk_classic_cs: assert property (w_ctrl & (id_q >= CLASSIC_ID) |=> cs_q == 8'h00)
		else $error("classic seed wrong");
	chk_err_release: assert property (err_stop & ~w_ctrl |=> st_q == ST_HDR ##1 lin_tx)
		else $error("bus not released on error");
	chk_rx_flag: assert property (uart_rx |=> sts_q[S_RXD] && hold_full_q)
		else $error("receive flag not set");
	chk_ovr_mark: assert property (uart_rx & hold_full_q & ~r_dat |=> ovp_q)
		else $error("overrun not marked");
	chk_framing_error_flag_flag: assert property (rdn & rfe & (st_q != ST_OFF) |=> err_q[E_FRAMING_ERROR_FLAG])
		else $error("framing error lost");
	chk_tx_flag: assert property (uart_ld |=> ~sts_q[S_TXD] && tbusy && ~lin_tx)
		else $error("uart send not started");
endmodule

// >>> verilog/lcs_pkg.sv
// Constants and types shared by the LIN/UART command sequencer
package lcs_pkg;
	// Register byte offsets
	localparam logic [7:0]  A_CTRL     = 8'h00;
	localparam logic [7:0]  A_STS      = 8'h04;
	localparam logic [7:0]  A_ERR      = 8'h08;
	localparam logic [7:0]  A_LEN      = 8'h0c;
	localparam logic [7:0]  A_ID       = 8'h10;
	localparam logic [7:0]  A_SEL      = 8'h14;
	localparam logic [7:0]  A_DATA     = 8'h18;
	localparam logic [7:0]  A_BAUD     = 8'h1c;
	// Field positions
	localparam int          C_ON       = 3;
	localparam int          C_LEG      = 4;
	localparam int          S_RXD      = 0;
	localparam int          S_TXD      = 1;
	localparam int          S_IDOK     = 2;
	localparam int          E_FRAMING_ERROR_FLAG     = 0;
	localparam int          E_OVR      = 1;
	localparam int          E_ABT      = 2;
	localparam int          E_PAR      = 3;
	localparam int          E_CS       = 4;
	localparam int          E_TMO      = 5;
	localparam int          SEL_AI     = 3;
	// Bus answers
	localparam logic [1:0]  RESP_OK    = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	// Bit timing: reset divisor gives 19200 baud at 125 MHz
	localparam int          CLK_HZ     = 125000000;
	localparam int          LIN_BAUD   = 19200;
	localparam logic [15:0] BAUD_RST   = 16'(CLK_HZ / LIN_BAUD);
	// Break: 13 dominant bits then one recessive delimiter
	localparam logic [13:0] BRK_FRAME  = 14'h2000;
	localparam logic [3:0]  BRK_LEN    = 4'he;
	localparam logic [3:0]  FRM_LEN    = 4'ha;
	localparam logic [7:0]  SYNC_CHR   = 8'h55;
	localparam logic [5:0]  CLASSIC_ID = 6'h3c;
	localparam logic [7:0]  TMO_MARGIN = 8'h1c;
	localparam logic [3:0]  DBUF_N     = 4'h8;
	localparam int          DBUF_DEPTH = 8;
	// Sequencer states
	typedef enum logic [5:0] {
		ST_OFF  = 6'b000001,
		ST_HDR  = 6'b000010,
		ST_TXH  = 6'b000100,
		ST_RXR  = 6'b001000,
		ST_TXR  = 6'b010000,
		ST_UART = 6'b100000
	} lcs_state_t;
endpackage

// >>> verilog/lcs_rxb.sv
// Serial byte receiver with input synchroniser and break detection
`timescale 1ns/1ns
module lcs_rxb (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        rx_pin,
	input  wire logic        en,
	input  wire logic [15:0] bit_cyc,
	output logic      [7:0]  byte_q,
	output logic             done_q,
	output logic             fe_q,
	output logic             brk_q
);
	logic        s1_q, s2_q, s3_q, lvl_q, lvp_q, act_q;
	logic [3:0]  bc_q;
	logic [15:0] tm_q;
	logic [8:0]  sh_q;
	logic        fall;

	assign fall = lvp_q & ~lvl_q;

	// Three-stage synchroniser; level moves once stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			lvl_q <= 1'b1;
			lvp_q <= 1'b1;
		end
		else
		begin
			s1_q  <= rx_pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (s2_q == s3_q) ? s3_q : lvl_q;
			lvp_q <= lvl_q;
		end
	end

	// Start, eight data bits LSB first, stop; sampled at mid-bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act_q  <= 1'b0;
			bc_q   <= 4'h0;
			tm_q   <= 16'h0000;
			sh_q   <= 9'h000;
			byte_q <= 8'h00;
			done_q <= 1'b0;
			fe_q   <= 1'b0;
			brk_q  <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (!en)
				act_q <= 1'b0;
			else if (!act_q)
			begin
				if (fall)
				begin
					act_q <= 1'b1;
					bc_q  <= 4'h0;
					tm_q  <= {1'b0, bit_cyc[15:1]};
				end
			end
			else if (tm_q != 16'h0000)
				tm_q <= tm_q - 16'h0001;
			else
			begin
				tm_q <= bit_cyc - 16'h0001;
				bc_q <= bc_q + 4'h1;
				sh_q <= {lvl_q, sh_q[8:1]};
				if (bc_q == 4'h0 && lvl_q)
					act_q <= 1'b0; // False start
				if (bc_q == 4'h9)
				begin
					act_q  <= 1'b0;
					byte_q <= sh_q[8:1];
					fe_q   <= ~lvl_q;
					brk_q  <= ~lvl_q & (sh_q[8:1] == 8'h00);
					done_q <= 1'b1;
				end
			end
		end
	end
endmodule

// >>> tb/lcs_peer.sv
// UART peer on the serial line: sends characters and records those it hears
`timescale 1ns/1ns
module lcs_peer #(
	parameter int BIT = 16
) (
	input  wire logic clk,
	input  wire logic lin_tx,
	output logic      lin_rx
);
	logic [7:0] got[$];
	logic [7:0] sh;

	initial lin_rx = 1'b1;

	// Start low, eight data bits LSB first, chosen stop level, then one idle bit
	task automatic send(input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			lin_rx <= f[i];
			repeat (BIT) @(posedge clk);
		end
		lin_rx <= 1'b1;
		repeat (BIT) @(posedge clk);
	endtask

	// Sample mid-bit after each falling edge; a break reads as a zero byte
	always
	begin
		@(negedge lin_tx);
		repeat (BIT + BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			sh[i] = lin_tx;
			repeat (BIT) @(posedge clk);
		end
		got.push_back(sh);
		wait (lin_tx === 1'b1);
	end
endmodule

// >>> tb/test_lin_uart_command_sequencer.sv
// Self-checking bench for the LIN/UART command sequencer
`timescale 1ns/1ns
module test_lin_uart_command_sequencer;
	import lcs_pkg::*;
	localparam int BIT = 16;
	logic        clk, rst_n, lin_rx, lin_tx;
	logic [7:0]  awaddr, araddr, b1, b2;
	logic [31:0] wdata, rdata, lfsr;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [5:0]  id;
	int          bad_count, checked;

	lcs_seq lcs_seq_i (.clk(clk), .rst_n(rst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .lin_rx(lin_rx),
		.lin_tx(lin_tx));
	lcs_peer #(.BIT(BIT)) lcs_peer_i (.clk(clk), .lin_tx(lin_tx), .lin_rx(lin_rx));

	// Free-running 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Identifier with its two check bits on top
	function automatic logic [7:0] prot(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
	endfunction

	// End-around-carry sum of seed and one data byte, inverted for the wire
	function automatic logic [7:0] csum(input logic [7:0] seed, input logic [7:0] d);
		logic [8:0] s;
		s = seed + d;
		return ~(s[7:0] + s[8]);
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write: address and data offered together, released at the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (bvalid !== 1'b1);
		check("bresp", bresp, er);
	endtask

	// Read and compare the masked word and the response code
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp, input logic [1:0] er = RESP_OK);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		check(what, rdata & m, exp);
		check("rresp", rresp, er);
	endtask

	task automatic waitq(input int n);
		for (int i = 0; i < 20 * BIT * n && lcs_peer_i.got.size() < n; i++)
			@(posedge clk);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Cut a hang short well beyond the expected run length
	initial
	begin
		repeat (60000) @(posedge clk);
		bad_count++;
		results();
	end

	initial
	begin
		rst_n = 1'b0;
		{awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
		{bready, rready, wstrb} = 6'h3f;
		lfsr = 32'h0001_04c3;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset values and an unmapped address
		rdc("ctrl", A_CTRL, 32'hff, 32'h0);
		rdc("len", A_LEN, 32'hff, 32'h0);
		rdc("id", A_ID, 32'hff, 32'h80);
		rdc("baud", A_BAUD, 32'hffff, 32'h196e);
		rdc("hole", 8'h20, 32'hffffffff, 32'h0, RESP_SLV);
		wr(8'h20, 32'h0, RESP_SLV);
		wr(A_BAUD, 32'(BIT));
		// Transmit-only service sends each written character
		wr(A_CTRL, 32'h0d);
		repeat (3)
		begin
			lfsr = nxt(lfsr);
			lcs_peer_i.got.delete();
			wr(A_DATA, {24'h0, lfsr[7:0]});
			rdc("txdone clr", A_STS, 32'h2, 32'h0);
			waitq(1);
			check("tx char", lcs_peer_i.got[0], lfsr[7:0]);
			repeat (2 * BIT) @(posedge clk);
			rdc("txdone set", A_STS, 32'h2, 32'h2);
		end
		// UART mode with both directions off keeps the transmitter quiet
		wr(A_CTRL, 32'h0c);
		lcs_peer_i.got.delete();
		wr(A_DATA, 32'ha5);
		repeat (12 * BIT) @(posedge clk);
		check("quiet", lcs_peer_i.got.size(), 0);
		// Receive-only service
		wr(A_CTRL, 32'h0e);
		repeat (3)
		begin
			lfsr = nxt(lfsr);
			lcs_peer_i.send(lfsr[7:0], 1'b1);
			repeat (2 * BIT) @(posedge clk);
			rdc("rxdone set", A_STS, 32'h1, 32'h1);
			rdc("rx char", A_DATA, 32'hff, {24'h0, lfsr[7:0]});
			rdc("rxdone clr", A_STS, 32'h1, 32'h0);
		end
		// Full duplex: overrun on a second unread character, then a bad stop bit
		wr(A_CTRL, 32'h0f);
		b1 = lfsr[15:8];
		b2 = lfsr[23:16];
		lcs_peer_i.send(b1, 1'b1);
		lcs_peer_i.send(b2, 1'b1);
		repeat (2 * BIT) @(posedge clk);
		rdc("overwrite", A_DATA, 32'hff, {24'h0, b2});
		rdc("overrun", A_ERR, 32'h2, 32'h2);
		lcs_peer_i.send(b1, 1'b0);
		repeat (2 * BIT) @(posedge clk);
		rdc("framing", A_ERR, 32'h1, 32'h1);
		wr(A_ERR, 32'h3f);
		rdc("err clr", A_ERR, 32'hff, 32'h0);
		// Disable in mid character releases the line at once
		wr(A_CTRL, 32'h0d);
		wr(A_DATA, 32'h00);
		repeat (3 * BIT) @(posedge clk);
		check("sending", lin_tx, 1'b0);
		wr(A_CTRL, 32'h00);
		check("off", lin_tx, 1'b1);
		// Abort each running LIN function
		for (int j = 1; j < 4; j++)
		begin
			wr(A_CTRL, 32'h08 | j);
			wr(A_CTRL, 32'h08);
			rdc("abort", A_ERR, 32'h4, 32'h4);
			check("released", lin_tx, 1'b1);
			wr(A_ERR, 32'h3f);
		end
		// Let the peer finish sampling the cut frames before counting bytes again
		repeat (12 * BIT) @(posedge clk);
		// Header then one-byte response, enhanced and classic checksum
		for (int k = 0; k < 2; k++)
		begin
			lfsr = nxt(lfsr);
			id = (k != 0) ? 6'h3c + 6'(lfsr[1:0]) : 6'(lfsr[5:0] % 6'h3c);
			b1 = lfsr[15:8];
			lcs_peer_i.got.delete();
			wr(A_CTRL, 32'h08);
			wr(A_ID, {26'h0, id});
			rdc("pid", A_ID, 32'hff, {24'h0, prot(id)});
			wr(A_CTRL, 32'h09);
			waitq(3);
			check("hdr bytes", lcs_peer_i.got.size(), 3);
			check("break", lcs_peer_i.got[0], 8'h00);
			check("sync", lcs_peer_i.got[1], SYNC_CHR);
			check("pid out", lcs_peer_i.got[2], prot(id));
			repeat (2 * BIT) @(posedge clk);
			rdc("hdr end", A_CTRL, 32'h7, 32'h0);
			rdc("id ok", A_STS, 32'h4, 32'h4);
			lcs_peer_i.got.delete();
			wr(A_LEN, 32'h10);
			wr(A_SEL, 32'h08);
			wr(A_DATA, {24'h0, b1});
			wr(A_STS, 32'h07);
			wr(A_CTRL, 32'h0b);
			waitq(2);
			check("resp data", lcs_peer_i.got[0], b1);
			check("checksum", lcs_peer_i.got[1], csum(k ? 8'h0 : prot(id), b1));
			repeat (2 * BIT) @(posedge clk);
			rdc("resp end", A_CTRL, 32'h7, 32'h0);
			rdc("tx ok", A_STS, 32'h2, 32'h2);
		end
		// Response reception, classic seed: good checksum ends it, a bad one stops it
		wr(A_LEN, 32'h01);
		for (int m = 0; m < 2; m++)
		begin
			lfsr = nxt(lfsr);
			b1 = lfsr[7:0];
			wr(A_STS, 32'h07);
			wr(A_CTRL, 32'h0a);
			lcs_peer_i.send(b1, 1'b1);
			lcs_peer_i.send(csum(8'h00, b1) ^ 8'(m), 1'b1);
			repeat (2 * BIT) @(posedge clk);
			rdc("rsp rx end", A_CTRL, 32'h7, 32'h0);
			rdc("rx ok", A_STS, 32'h1, (m != 0) ? 32'h0 : 32'h1);
			rdc("cs err", A_ERR, 32'h10, (m != 0) ? 32'h10 : 32'h0);
		end
		wr(A_SEL, 32'h08);
		rdc("rx data", A_DATA, 32'hff, {24'h0, b1});
		results();
	end
endmodule
